//--- audio_volume_consts.svh
// Overview of operation
// - Right record gain: half-dB steps; 7Fh +20 dB, 57h 0 dB, 07h -40 dB.
// - Right record gain code below 07h mutes with the same soft-stepped ramp.
// - Applied right record gain always ramps toward a new code, never jumps.
// - Right record silence bit resets to one; zero makes channel active.
// - Right record gain field resets to 1010111, unity gain.
// - Silenced playback channel feeds all-zero samples to its interpolation filter.
// - Left playback silence ramps gain to floor then zeros; clearing ramps back.
// - Right playback silence ramps gain down then zeros; clearing ramps back.
// - Playback gain code half-dB steps: 7Fh 0 dB, 00h -63.5 dB.
// - Both playback gain fields reset to 1111111, 0 dB.
// - Playback register: left silence 15, left gain 14:8, right silence 7, gain 6:0.
// - Both playback silence bits reset to one.
// - Left thru silence ramps gain to floor then cuts left line path.
// - Right thru silence ramps gain down then cuts right line path.
// - Thru gain code half-dB steps: 7Fh +12 dB, 67h 0 dB, 20h -35.5 dB.
// - Thru gain codes 0 to 31 request mute of that path.
// - Both thru gain fields reset to 1100111, unity gain.
// - Both thru silence bits reset to one.
// - Thru register: left silence 15, left gain 14:8, right silence 7, gain 6:0.
// - Applied gain steps once per 20 us, or 40 us at half rate.
// - Ramp done flag reads one when all ramps finished, zero otherwise.
`ifndef AUDIO_VOLUME_CONSTS_SVH
`define AUDIO_VOLUME_CONSTS_SVH
`define REC_GAIN_ADDR      4'h1
`define PLAY_GAIN_ADDR     4'h2
`define THRU_GAIN_ADDR     4'h3
`define RAMP_CTRL_ADDR     4'h4
`define LEFT_SILENCE_BIT   15
`define LEFT_GAIN_HI       14
`define LEFT_GAIN_LO       8
`define RIGHT_SILENCE_BIT  7
`define RIGHT_GAIN_HI      6
`define RIGHT_GAIN_LO      0
`define HALF_RATE_BIT      1
`define DONE_BIT           0
`define REC_GAIN_RESET     7'h57
`define REC_GAIN_FLOOR     7'h07
`define PLAY_GAIN_RESET    7'h7f
`define PLAY_GAIN_FLOOR    7'h00
`define THRU_GAIN_RESET    7'h67
`define THRU_GAIN_FLOOR    7'h20
`define CLK_MHZ            40
`define STEP_TIME_US       20
`define STEP_CYCLES        (`STEP_TIME_US * `CLK_MHZ)
`endif

//--- audio_volume_mute_regs.sv
`include "audio_volume_consts.svh"
// Volume and mute registers with soft-stepped applied gains
module audio_volume_mute_regs
#(
   parameter int STEP_CYCLES = `STEP_CYCLES
)(
   input  wire logic                    sys_clk,
   input  wire logic                    sys_rst,
   input  wire logic                    regWrite,
   input  wire audio_volume_pkg::addr_t regAddr,
   input  wire audio_volume_pkg::word_t regWdata,
   output audio_volume_pkg::word_t      regRdata,
   input  wire logic                    regRightRecWrite,
   input  wire audio_volume_pkg::word_t regRightRecData,
   input  wire logic signed [19:0]      playLeftSample,
   input  wire logic signed [19:0]      playRightSample,
   output logic signed [19:0]           playLeftFilterIn,
   output logic signed [19:0]           playRightFilterIn,
   output audio_volume_pkg::gain_t      recRightApplied,
   output logic                         recRightCut,
   output audio_volume_pkg::gain_t      playLeftApplied,
   output audio_volume_pkg::gain_t      playRightApplied,
   output audio_volume_pkg::gain_t      thruLeftApplied,
   output audio_volume_pkg::gain_t      thruRightApplied,
   output logic                         leftLineInputPass,
   output logic                         rightLineInputPass,
   output logic                         ramp_done_flag
);
   import audio_volume_pkg::*;

   // ------------------------------------------------------------
   // Register storage
   // ------------------------------------------------------------
   logic  rec_right_silence,  next_rec_right_silence;
   gain_t rec_right_gain,     next_rec_right_gain;
   logic  play_left_silence,  next_play_left_silence;
   gain_t play_left_gain,     next_play_left_gain;
   logic  play_right_silence, next_play_right_silence;
   gain_t play_right_gain,    next_play_right_gain;
   logic  thru_left_silence,  next_thru_left_silence;
   gain_t thru_left_gain,     next_thru_left_gain;
   logic  thru_right_silence, next_thru_right_silence;
   gain_t thru_right_gain,    next_thru_right_gain;
   logic  ramp_half_rate,     next_ramp_half_rate;

   // Decode writes per field
   always_comb
   begin
      next_rec_right_silence  = rec_right_silence;
      next_rec_right_gain     = rec_right_gain;
      next_play_left_silence  = play_left_silence;
      next_play_left_gain     = play_left_gain;
      next_play_right_silence = play_right_silence;
      next_play_right_gain    = play_right_gain;
      next_thru_left_silence  = thru_left_silence;
      next_thru_left_gain     = thru_left_gain;
      next_thru_right_silence = thru_right_silence;
      next_thru_right_gain    = thru_right_gain;
      next_ramp_half_rate     = ramp_half_rate;
      if (regRightRecWrite)
      begin
         next_rec_right_silence = regRightRecData[`RIGHT_SILENCE_BIT];
         next_rec_right_gain    = regRightRecData[`RIGHT_GAIN_HI:`RIGHT_GAIN_LO];
      end
      if (regWrite)
      begin
         unique case (regAddr)
            `PLAY_GAIN_ADDR:
            begin
               next_play_left_silence  = regWdata[`LEFT_SILENCE_BIT];
               next_play_left_gain     = regWdata[`LEFT_GAIN_HI:`LEFT_GAIN_LO];
               next_play_right_silence = regWdata[`RIGHT_SILENCE_BIT];
               next_play_right_gain    = regWdata[`RIGHT_GAIN_HI:`RIGHT_GAIN_LO];
            end
            `THRU_GAIN_ADDR:
            begin
               next_thru_left_silence  = regWdata[`LEFT_SILENCE_BIT];
               next_thru_left_gain     = regWdata[`LEFT_GAIN_HI:`LEFT_GAIN_LO];
               next_thru_right_silence = regWdata[`RIGHT_SILENCE_BIT];
               next_thru_right_gain    = regWdata[`RIGHT_GAIN_HI:`RIGHT_GAIN_LO];
            end
            `RAMP_CTRL_ADDR:
               next_ramp_half_rate = regWdata[`HALF_RATE_BIT];
            default:
               next_ramp_half_rate = ramp_half_rate;
         endcase
      end
   end

   // Field registers with documented reset values
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rec_right_silence  <= 1'b1;
         rec_right_gain     <= `REC_GAIN_RESET;
         play_left_silence  <= 1'b1;
         play_left_gain     <= `PLAY_GAIN_RESET;
         play_right_silence <= 1'b1;
         play_right_gain    <= `PLAY_GAIN_RESET;
         thru_left_silence  <= 1'b1;
         thru_left_gain     <= `THRU_GAIN_RESET;
         thru_right_silence <= 1'b1;
         thru_right_gain    <= `THRU_GAIN_RESET;
         ramp_half_rate     <= 1'b0;
      end
      else
      begin
         rec_right_silence  <= next_rec_right_silence;
         rec_right_gain     <= next_rec_right_gain;
         play_left_silence  <= next_play_left_silence;
         play_left_gain     <= next_play_left_gain;
         play_right_silence <= next_play_right_silence;
         play_right_gain    <= next_play_right_gain;
         thru_left_silence  <= next_thru_left_silence;
         thru_left_gain     <= next_thru_left_gain;
         thru_right_silence <= next_thru_right_silence;
         thru_right_gain    <= next_thru_right_gain;
         ramp_half_rate     <= next_ramp_half_rate;
      end
   end

   // ------------------------------------------------------------
   // Soft-step rate divider
   // ------------------------------------------------------------
   logic [16:0] stepCount, next_stepCount;
   logic        stepEn;
   logic [16:0] stepLimit;

   // Half rate doubles the period between steps
   always_comb
   begin
      stepLimit = ramp_half_rate ? 17'(2 * STEP_CYCLES - 1) : 17'(STEP_CYCLES - 1);
      stepEn    = (stepCount >= stepLimit);
      next_stepCount = stepEn ? 17'h00000 : stepCount + 17'h00001;
   end

   // Divider register
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         stepCount <= 17'h00000;
      else
         stepCount <= next_stepCount;
   end

   // ------------------------------------------------------------
   // Channel ramps
   // ------------------------------------------------------------
   logic [4:0] busy;
   logic       playLeftCut, playRightCut, thruLeftCut, thruRightCut;

   // Right record channel; codes below its floor count as silence
   gain_ramp #(.FLOOR(`REC_GAIN_FLOOR)) u_rec_right
   (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .stepEn  (stepEn),
      .silence (rec_right_silence),
      .code    (rec_right_gain),
      .applied (recRightApplied),
      .cut     (recRightCut),
      .busy    (busy[0])
   );

   // Left playback channel
   gain_ramp #(.FLOOR(`PLAY_GAIN_FLOOR)) u_play_left
   (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .stepEn  (stepEn),
      .silence (play_left_silence),
      .code    (play_left_gain),
      .applied (playLeftApplied),
      .cut     (playLeftCut),
      .busy    (busy[1])
   );

   // Right playback channel
   gain_ramp #(.FLOOR(`PLAY_GAIN_FLOOR)) u_play_right
   (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .stepEn  (stepEn),
      .silence (play_right_silence),
      .code    (play_right_gain),
      .applied (playRightApplied),
      .cut     (playRightCut),
      .busy    (busy[2])
   );

   // Left thru path; codes below its floor count as silence
   gain_ramp #(.FLOOR(`THRU_GAIN_FLOOR)) u_thru_left
   (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .stepEn  (stepEn),
      .silence (thru_left_silence),
      .code    (thru_left_gain),
      .applied (thruLeftApplied),
      .cut     (thruLeftCut),
      .busy    (busy[3])
   );

   // Right thru path
   gain_ramp #(.FLOOR(`THRU_GAIN_FLOOR)) u_thru_right
   (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .stepEn  (stepEn),
      .silence (thru_right_silence),
      .code    (thru_right_gain),
      .applied (thruRightApplied),
      .cut     (thruRightCut),
      .busy    (busy[4])
   );

   // Path switches and completion flag
   assign leftLineInputPass  = !thruLeftCut;
   assign rightLineInputPass = !thruRightCut;
   assign ramp_done_flag     = ~|busy;

   // ------------------------------------------------------------
   // Playback sample gating
   // ------------------------------------------------------------
   logic signed [19:0] next_playLeftFilterIn;
   logic signed [19:0] next_playRightFilterIn;

   // A cut channel feeds zeros so the filter never sees stale audio
   always_comb
   begin
      next_playLeftFilterIn  = playLeftCut  ? 20'sh00000 : playLeftSample;
      next_playRightFilterIn = playRightCut ? 20'sh00000 : playRightSample;
   end

   // Filter input registers
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         playLeftFilterIn  <= 20'sh00000;
         playRightFilterIn <= 20'sh00000;
      end
      else
      begin
         playLeftFilterIn  <= next_playLeftFilterIn;
         playRightFilterIn <= next_playRightFilterIn;
      end
   end

   // ------------------------------------------------------------
   // Read back
   // ------------------------------------------------------------
   // Combinational readback; unmapped addresses read zero
   always_comb
   begin
      unique case (regAddr)
         `REC_GAIN_ADDR:  regRdata = {8'h00, rec_right_silence, rec_right_gain};
         `PLAY_GAIN_ADDR: regRdata = {play_left_silence, play_left_gain, play_right_silence, play_right_gain};
         `THRU_GAIN_ADDR: regRdata = {thru_left_silence, thru_left_gain, thru_right_silence, thru_right_gain};
         `RAMP_CTRL_ADDR: regRdata = {14'h0000, ramp_half_rate, ramp_done_flag};
         default:         regRdata = 16'h0000;
      endcase
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // Left playback silenced, ramped to the floor, still open
   sequence s_left_at_floor;
      play_left_silence && !playLeftCut && playLeftApplied == `PLAY_GAIN_FLOOR;
   endsequence

   // Left playback released while still cut
   sequence s_left_reopen;
      !play_left_silence && playLeftCut;
   endsequence

   chk_zero_muted: assert property (@(posedge sys_clk) disable iff (sys_rst)
      playLeftCut |=> playLeftFilterIn == 20'sh00000) else $error("audio while muted");

   chk_zero_right: assert property (@(posedge sys_clk) disable iff (sys_rst)
      playRightCut |=> playRightFilterIn == 20'sh00000) else $error("right audio while muted");

   chk_step_period: assert property (@(posedge sys_clk) disable iff (sys_rst)
      stepEn && !ramp_half_rate |=> !stepEn [*3]) else $error("steps too close");

   chk_half_gap: assert property (@(posedge sys_clk) disable iff (sys_rst)
      stepEn && ramp_half_rate |=> (!stepEn || !ramp_half_rate) [*7]) else $error("half rate too fast");

   chk_done_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (recRightApplied != rec_right_gain && !rec_right_silence && rec_right_gain >= `REC_GAIN_FLOOR)
      |-> !ramp_done_flag) else $error("done during ramp");

   chk_mute_cuts: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_left_at_floor ##0 stepEn |=> playLeftCut) else $error("floor reached but not cut");

   chk_unmute_opens: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_left_reopen ##0 stepEn |=> !playLeftCut && playLeftApplied == `PLAY_GAIN_FLOOR)
      else $error("unmute did not reopen at floor");

   chk_play_lands: assert property (@(posedge sys_clk) disable iff (sys_rst)
      regWrite && regAddr == `PLAY_GAIN_ADDR |=> play_left_silence == $past(regWdata[`LEFT_SILENCE_BIT])
      && play_left_gain == $past(regWdata[`LEFT_GAIN_HI:`LEFT_GAIN_LO])) else $error("playback write lost");

   chk_thru_lands: assert property (@(posedge sys_clk) disable iff (sys_rst)
      regWrite && regAddr == `THRU_GAIN_ADDR |=> thru_right_silence == $past(regWdata[`RIGHT_SILENCE_BIT])
      && thru_right_gain == $past(regWdata[`RIGHT_GAIN_HI:`RIGHT_GAIN_LO])) else $error("thru write lost");
endmodule : audio_volume_mute_regs

//--- audio_volume_mute_regs_tb.sv
`include "audio_volume_consts.svh"
module audio_volume_mute_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import audio_volume_pkg::*;

   // ----------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------
   localparam int STEP = 4;
   logic               sys_clk = 1'b0;
   logic               sys_rst = 1'b1;
   logic               regWrite = 1'b0;
   addr_t              regAddr = 4'h0;
   word_t              regWdata = 16'h0000;
   word_t              regRdata;
   logic               regRightRecWrite = 1'b0;
   word_t              regRightRecData = 16'h0000;
   logic signed [19:0] playLeftSample = 20'sh12345;
   logic signed [19:0] playRightSample = -20'sh0abcd;
   logic signed [19:0] playLeftFilterIn, playRightFilterIn;
   gain_t              recRightApplied, playLeftApplied, playRightApplied;
   gain_t              thruLeftApplied, thruRightApplied;
   logic               recRightCut, leftLineInputPass, rightLineInputPass, ramp_done_flag;
   logic [34:0]        allApplied;
   int                 numErrors = 0;
   int                 nChecks = 0;

   assign allApplied = {recRightApplied, playLeftApplied, playRightApplied, thruLeftApplied, thruRightApplied};

   // Clock at 40 MHz
   always #12.5 sys_clk = ~sys_clk;

   audio_volume_mute_regs #(.STEP_CYCLES(STEP)) audio_volume_mute_regs_inst (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .regWrite(regWrite), .regAddr(regAddr),
      .regWdata(regWdata), .regRdata(regRdata), .regRightRecWrite(regRightRecWrite),
      .regRightRecData(regRightRecData), .playLeftSample(playLeftSample),
      .playRightSample(playRightSample), .playLeftFilterIn(playLeftFilterIn),
      .playRightFilterIn(playRightFilterIn), .recRightApplied(recRightApplied),
      .recRightCut(recRightCut), .playLeftApplied(playLeftApplied),
      .playRightApplied(playRightApplied), .thruLeftApplied(thruLeftApplied),
      .thruRightApplied(thruRightApplied), .leftLineInputPass(leftLineInputPass),
      .rightLineInputPass(rightLineInputPass), .ramp_done_flag(ramp_done_flag));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string name, input logic [19:0] exp, input logic [19:0] got);
      nChecks++;
      if (got !== exp)
      begin
         $display("unexpected %s expected %h seen %h", name, exp, got);
         numErrors++;
      end
   endtask : chk

   // One write pulse; the field is updated at the closing edge
   task automatic wr(input addr_t a, input word_t d);
      @(posedge sys_clk);
      regWrite <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge sys_clk);
      regWrite <= 1'b0;
      #1;
   endtask : wr

   task automatic recWr(input logic [7:0] d);
      @(posedge sys_clk);
      regRightRecWrite <= 1'b1;
      regRightRecData  <= {8'h00, d};
      @(posedge sys_clk);
      regRightRecWrite <= 1'b0;
      #1;
   endtask : recWr

   // Combinational readback of one address
   task automatic rd(input addr_t a, input word_t mask, input word_t exp, input string name);
      @(posedge sys_clk);
      regAddr <= a;
      #1;
      chk(name, {4'h0, exp & mask}, {4'h0, regRdata & mask});
   endtask : rd

   // Waits for all ramps to finish; every applied gain moves one code at most per cycle
   task automatic settle(input int maxCycles, output int n);
      logic [34:0] prev;
      logic        ok;
      int          a, b;
      n = 0;
      ok = 1'b1;
      prev = allApplied;
      chk("doneLow", 1'b0, ramp_done_flag);
      while (ramp_done_flag !== 1'b1 && n < maxCycles)
      begin
         @(posedge sys_clk);
         #1;
         for (int i = 0; i < 5; i++)
         begin
            a = int'(prev[i*7 +: 7]);
            b = int'(allApplied[i*7 +: 7]);
            if (a - b > 1 || b - a > 1)
               ok = 1'b0;
         end
         prev = allApplied;
         n++;
      end
      @(posedge sys_clk);   // Filter inputs trail the cut flag by one register
      #1;
      chk("stepSize", 1'b1, ok);
      chk("settled", 1'b1, n < maxCycles);
   endtask : settle

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic test_reset();
      rd(`PLAY_GAIN_ADDR, 16'hffff, 16'hffff, "playReset");
      rd(`THRU_GAIN_ADDR, 16'hffff, 16'he7e7, "thruReset");
      rd(`REC_GAIN_ADDR, 16'h00ff, 16'h00d7, "recReset");
      rd(`RAMP_CTRL_ADDR, 16'h0003, 16'h0001, "rampCtrlReset");
      rd(4'hf, 16'hffff, 16'h0000, "unmapped");
      chk("filterLeftReset", 20'h0, playLeftFilterIn);
      chk("passReset", 2'b00, {leftLineInputPass, rightLineInputPass});
      chk("recCutReset", 1'b1, recRightCut);
   endtask : test_reset

   task automatic test_play();
      int n;
      wr(`PLAY_GAIN_ADDR, 16'h7f7f);
      settle(1000, n);
      chk("playLeftUp", 7'h7f, playLeftApplied);
      chk("playLeftLive", 20'h12345, playLeftFilterIn);
      wr(4'hf, 16'h0000);
      rd(`PLAY_GAIN_ADDR, 16'hffff, 16'h7f7f, "unmappedWrite");
   endtask : test_play

   task automatic test_half_rate();
      int n;
      wr(`RAMP_CTRL_ADDR, 16'h0002);
      rd(`RAMP_CTRL_ADDR, 16'h0003, 16'h0003, "halfRateBit");
      wr(`PLAY_GAIN_ADDR, 16'h7f70);
      settle(1000, n);
      chk("halfRateSpan", 1'b1, n >= 14 * 2 * STEP && n <= 16 * 2 * STEP);
      chk("playRightDown", 7'h70, playRightApplied);
      wr(`PLAY_GAIN_ADDR, 16'h7f40);
      repeat (10 * 2 * STEP) @(posedge sys_clk);
      #1;
      chk("midRamp", 1'b1, playRightApplied < 7'h70 && playRightApplied > 7'h40);
      wr(`PLAY_GAIN_ADDR, 16'h7f78);
      settle(1000, n);
      chk("retarget", 7'h78, playRightApplied);
   endtask : test_half_rate

   task automatic test_mute();
      int n;
      wr(`PLAY_GAIN_ADDR, 16'hff70);
      settle(3000, n);
      chk("playLeftFloor", 7'h00, playLeftApplied);
      chk("playLeftZero", 20'h0, playLeftFilterIn);
      chk("playRightKept", 20'hf5433, playRightFilterIn);
      rd(`PLAY_GAIN_ADDR, 16'hffff, 16'hff70, "playCodeKept");
      wr(`PLAY_GAIN_ADDR, 16'h7ff0);
      settle(3000, n);
      chk("playLeftBack", 7'h7f, playLeftApplied);
      chk("playRightZero", 20'h0, playRightFilterIn);
   endtask : test_mute

   task automatic test_thru();
      int n;
      wr(`THRU_GAIN_ADDR, 16'h301f);
      settle(1000, n);
      chk("thruLeftGain", 7'h30, thruLeftApplied);
      chk("thruPass", 2'b10, {leftLineInputPass, rightLineInputPass});
      chk("thruRightFloor", 7'h20, thruRightApplied);
      wr(`THRU_GAIN_ADDR, 16'hb020);
      settle(1000, n);
      chk("thruLeftFloor", 7'h20, thruLeftApplied);
      chk("thruPassSwap", 2'b01, {leftLineInputPass, rightLineInputPass});
   endtask : test_thru

   task automatic test_rec();
      int n;
      recWr(8'h05);
      repeat (4 * STEP) @(posedge sys_clk);
      #1;
      chk("recLowCodeCut", 1'b1, recRightCut);
      recWr(8'h60);
      settle(3000, n);
      chk("recGain", 7'h60, recRightApplied);
      chk("recLive", 1'b0, recRightCut);
      recWr(8'he0);
      settle(3000, n);
      chk("recFloor", 7'h07, recRightApplied);
      chk("recMuted", 1'b1, recRightCut);
      rd(`REC_GAIN_ADDR, 16'h00ff, 16'h00e0, "recCodeKept");
   endtask : test_rec

   // ----------------------------------------
   // Verdict, watchdog and main sequence
   // ----------------------------------------
   task automatic print_verdict();
      if (numErrors == 0 && nChecks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : print_verdict

   // Cuts a hang well beyond the expected run of a few thousand cycles
   initial
   begin
      #500000;
      numErrors++;
      print_verdict();
   end

   initial
   begin
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      #1;
      test_reset();
      test_play();
      test_half_rate();
      test_mute();
      test_thru();
      test_rec();
      print_verdict();
   end
endmodule : audio_volume_mute_regs_tb

//--- audio_volume_pkg.sv
package audio_volume_pkg;
   typedef logic [6:0]  gain_t;
   typedef logic [15:0] word_t;
   typedef logic [3:0]  addr_t;
endpackage : audio_volume_pkg

//--- gain_ramp.sv
`include "audio_volume_consts.svh"
// One channel: walks the applied gain one code per step toward a target
module gain_ramp
   import audio_volume_pkg::*;
#(
   parameter gain_t FLOOR = 7'h00
)(
   input  wire logic                  sys_clk,
   input  wire logic                  sys_rst,
   input  wire logic                  stepEn,
   input  wire logic                  silence,
   input  wire audio_volume_pkg::gain_t code,
   output audio_volume_pkg::gain_t    applied,
   output logic                       cut,
   output logic                       busy
);
   gain_t target;
   gain_t next_applied;
   logic  next_cut;
   logic  wantMute;

   // Target is the floor while muting, else the stored code
   always_comb
   begin
      wantMute = silence || (code < FLOOR);
      target   = wantMute ? FLOOR : code;
      next_applied = applied;
      next_cut     = cut;
      if (stepEn)
      begin
         if (cut && !wantMute)
            next_cut = 1'b0;                               // Reopen at floor before ramping up
         else if (applied < target)
            next_applied = applied + 7'h01;
         else if (applied > target)
            next_applied = applied - 7'h01;
         else if (wantMute)
            next_cut = 1'b1;
      end
   end

   // State registers; out of reset the channel sits cut at the floor
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         applied <= FLOOR;
         cut     <= 1'b1;
      end
      else
      begin
         applied <= next_applied;
         cut     <= next_cut;
      end
   end

   assign busy = (applied != target) || (cut != wantMute);

   chk_step_one: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !stepEn |=> $stable(applied)) else $error("gain moved without step");
   chk_cut_floor: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(cut) |-> applied == FLOOR) else $error("cut before floor");
   chk_no_jump: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ##1 (applied == $past(applied) || applied == $past(applied) + 7'h01
           || applied == $past(applied) - 7'h01)) else $error("gain jumped");
   chk_muted_floor: assert property (@(posedge sys_clk) disable iff (sys_rst)
      cut |-> applied == FLOOR) else $error("cut away from floor");
   chk_open_floor: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $fell(cut) |-> applied == FLOOR) else $error("reopened away from floor");
endmodule : gain_ramp
